// File: bench/sffp_front_end_chk.sv
// assertion checker on the front end ports
`timescale 1ns/100ps
`default_nettype none
module sffp_front_end_chk
  import sffp_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rstn_i,
  input wire logic       cs_n_i,
  input wire logic [3:0] io_oe_o,
  input wire sffp_cfg_s  cfg_i,
  input wire sffp_cmd_s  exec_o,
  input wire logic       write_latch_o,
  input wire logic       busy_o,
  input wire logic       four_lane_command_mode_o,
  input wire logic       paused_o,
  input wire logic       reject_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_exec; exec_o.valid ##1 busy_o; endsequence
  sequence s_quiet; cs_n_i [*4]; endsequence
  property p_latch; exec_o.valid |-> $past(write_latch_o); endproperty
  property p_idle; exec_o.valid |-> !$past(busy_o); endproperty
  property p_busy; exec_o.valid |-> s_exec; endproperty
  property p_excl; reject_o |-> !exec_o.valid; endproperty
  property p_rej; reject_o |=> !reject_o; endproperty
  property p_one; exec_o.valid |=> !exec_o.valid; endproperty
  property p_4l; $rose(four_lane_command_mode_o) |-> cfg_i.four_lane_enable; endproperty
  property p_z; s_quiet |-> io_oe_o == 4'h0; endproperty
  property p_np; cfg_i.four_lane_enable [*2] |-> !paused_o; endproperty
  a_latch: assert property (p_latch) else $error("exec without write latch");
  a_idle: assert property (p_idle) else $error("exec while busy");
  a_busy: assert property (p_busy) else $error("no busy after exec");
  a_excl: assert property (p_excl) else $error("exec and reject together");
  a_rej: assert property (p_rej) else $error("reject longer than a pulse");
  a_one: assert property (p_one) else $error("exec longer than a pulse");
  a_4l: assert property (p_4l) else $error("four lane mode without enable");
  a_z: assert property (p_z) else $error("lanes driven while deselected");
  a_np: assert property (p_np) else $error("pause with four lane enable");
endmodule : sffp_front_end_chk
`default_nettype wire

// File: bench/sffp_host_model.sv
// spi host model: mode 0 frames, msb first on lane 0, reads lane 1
`timescale 1ns/100ps
`default_nettype none
module sffp_host_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  logic [7:0] rx;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
    rx     = 8'h00;
  end
  // clock stands low outside frames; extra bits clock out read data
  task automatic frame(input logic [31:0] b, input int n, input int extra);
    cs_n_o = 1'b0;
    for (int i = 0; i < n + extra; i++) begin
      mosi_o = (i < n) ? b[n-1-i] : ~mosi_o;
      #6 sclk_o = 1'b1;
      rx = {rx[6:0], miso_i};
      #6 sclk_o = 1'b0;
    end
    #6 cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line must not keep its last value
    #30;
  endtask : frame
endmodule : sffp_host_model
`default_nettype wire

// File: bench/test_sffp_front_end.sv
// self-checking bench for the serial flash front end
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module test_sffp_front_end;
  import sffp_pkg::*;
  logic                  core_clk_i, rstn_i, hold_n, lock_clr_i, seen_x, seen_r;
  logic [SECT_IDX_W-1:0] lock_idx_i;
  logic [22:0]           last_addr;
  sffp_cfg_s             cfg_i;
  sffp_cmd_s             exec_o;
  wire logic             sclk, cs_n, mosi, write_latch_o, busy_o, fl_mode, paused_o, reject_o;
  wire logic [3:0]       io_i, io_o, io_oe_o;
  int                    err_total, check_count;
  // sections of {sel, invert, expect exec, address}
  localparam logic [39:0] TAB [10] = '{40'h01_0_0_7E0000, 40'h01_0_1_7DF000,
    40'h00_0_1_7FF000, 40'h07_0_0_000000, 40'h00_1_0_7FF000, 40'h07_1_1_000000,
    40'h01_1_1_7E0000, 40'h01_1_0_7DF000, 40'h19_1_1_000000, 40'h19_1_0_001000};
  assign io_i = {hold_n, 1'b1, io_oe_o[1] ? io_o[1] : ~mosi, mosi};
  sffp_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(io_o[1]));
  sffp_front_end #(.SW_RESET_CYCLES(50), .OP_BUSY_CYCLES(300)) dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_i),
    .io_o(io_o), .io_oe_o(io_oe_o), .cfg_i(cfg_i), .read_data_i(8'hA5),
    .lock_clr_i(lock_clr_i), .lock_idx_i(lock_idx_i), .exec_o(exec_o),
    .write_latch_o(write_latch_o), .busy_o(busy_o), .four_lane_command_mode_o(fl_mode),
    .paused_o(paused_o), .reject_o(reject_o));
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (exec_o.valid === 1'b1) begin
      seen_x <= 1'b1;
      last_addr <= exec_o.addr;
    end
    if (reject_o === 1'b1) seen_r <= 1'b1;
  end
  task automatic cmd(input logic [31:0] b, input int n);
    @(negedge core_clk_i);
    seen_x = 1'b0;
    seen_r = 1'b0;
    host.frame(b, n, 0);
    repeat (8) @(negedge core_clk_i); // answer lands a few cycles after the frame
  endtask : cmd
  task automatic wait_idle();
    for (int i = 0; i < 400 && busy_o !== 1'b0; i++) @(negedge core_clk_i);
  endtask : wait_idle
  task automatic erase(input logic [23:0] a, input logic e);
    cmd({24'h0, CMD_WRITE_UNLOCK}, 8);
    cmd({CMD_SECT_ERASE, a}, 32);
    `CHK("exec", e, seen_x)
    `CHK("reject", ~e, seen_r)
    if (e) `CHK("addr", a[22:0], last_addr)
    wait_idle();
  endtask : erase
  task automatic pin_reset(input logic f);
    @(negedge core_clk_i);
    cfg_i.four_lane_enable = f;
    hold_n = 1'b0;
    repeat (HARD_RESET_CYC + 10) @(negedge core_clk_i);
    hold_n = 1'b1;
    repeat (8) @(negedge core_clk_i);
  endtask : pin_reset
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  initial begin
    {rstn_i, hold_n, lock_clr_i, seen_x, seen_r} = 5'b01000;
    cfg_i = '0;
    lock_idx_i = '0;
    last_addr = '0;
    repeat (20) @(negedge core_clk_i);
    rstn_i = 1'b1;
    cmd({CMD_SECT_ERASE, 24'h0}, 32);
    `CHK("nolatch", 1'b1, seen_r)
    host.frame({CMD_READ, 24'h0}, 32, 8);
    `CHK("read", 8'hA5, host.rx)
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk_i);
      cfg_i.prot_sel = TAB[i][36:32];
      cfg_i.range_invert_bit = TAB[i][28];
      erase(TAB[i][23:0], TAB[i][24]);
    end
    $display("range decode done");
    cfg_i = '0;
    cfg_i.lock_scheme_select = 1'b1;
    erase(24'h000000, 1'b0);
    @(negedge core_clk_i) lock_clr_i = 1'b1;
    @(negedge core_clk_i) lock_clr_i = 1'b0;
    erase(24'h000000, 1'b1);
    erase(24'h001000, 1'b0);
    cmd({24'h0, CMD_WRITE_UNLOCK}, 8);
    cmd({1'b0, CMD_SECT_ERASE, 23'h0}, 31);
    `CHK("unaligned", 1'b1, seen_r)
    cmd({24'h0, CMD_WRITE_UNLOCK}, 8);
    cmd({CMD_SECT_ERASE, 24'h0}, 32);
    cmd({24'h0, CMD_WRITE_UNLOCK}, 8);
    cmd({CMD_SECT_ERASE, 24'h0}, 32);
    `CHK("busy reject", 1'b1, seen_r)
    wait_idle();
    $display("lock and framing done");
    cmd({24'h0, CMD_ENTER_4L}, 8);
    `CHK("4l off", 1'b0, fl_mode)
    cfg_i.four_lane_enable = 1'b1;
    cmd({24'h0, CMD_ENTER_4L}, 8);
    `CHK("4l on", 1'b1, fl_mode)
    rstn_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    rstn_i = 1'b1;
    cfg_i.four_lane_enable = 1'b0;
    `CHK("4l reset", 1'b0, fl_mode)
    $display("four lane done");
    cmd({24'h0, CMD_WRITE_UNLOCK}, 8);
    cmd({24'h0, CMD_RESET_EN}, 8);
    cmd({24'h0, CMD_RESET}, 8);
    `CHK("sw busy", 1'b1, busy_o)
    wait_idle();
    `CHK("sw latch", 1'b0, write_latch_o)
    cmd({24'h0, CMD_RESET_EN}, 8);
    cmd({24'h0, CMD_WRITE_UNLOCK}, 8);
    cmd({24'h0, CMD_RESET}, 8);
    `CHK("cancel", 1'b1, write_latch_o)
    cfg_i.pause_reset_select = 1'b1;
    pin_reset(1'b1);
    `CHK("pin off", 1'b1, write_latch_o)
    pin_reset(1'b0);
    `CHK("pin reset", 1'b0, write_latch_o)
    $display("resets done");
    complete_run();
  end
endmodule : test_sffp_front_end
bind sffp_front_end sffp_front_end_chk chk (.core_clk_i, .rstn_i, .cs_n_i, .io_oe_o,
  .cfg_i, .exec_o, .write_latch_o, .busy_o, .four_lane_command_mode_o, .paused_o, .reject_o);
`default_nettype wire

// File: rtl/sffp_front_end.sv
// serial flash front end: framing, lane modes, protection decode, resets
// Function
// [R1] invert bit on: protect complement of normal range decode
// [R2] drop erase or program touching any protected region
// [R3] per-sector locks apply only when lock scheme select is one
// [R4] all lock bits set after reset so whole array protected
// [R5] 8MB array: 4K sectors, 256B pages, 2048 sectors, sector/block/chip erase
// [R6] invalid opcode: standby, output tristate until next select fall
// [R7] valid opcode: active until select rises
// [R8] sample on sclk rise, shift out on sclk fall, modes 0 and 3
// [R9] read commands drive data; host may end after any bit
// [R10] write-class commands rejected unless select rises on byte boundary; code bit count holds at 40, so longer frames always pass as aligned
// [R11] array access ignored while status write, program or erase busy
// [R12] dual reads use lanes 0 and 1, two bits per clock; code still shifts one bit per clock in and out
// [R13] quad reads use lanes 2 and 3, need four lane enable; code drives all four lanes 0 to 3
// [R14] four-lane command mode via 38h/FFh, exclusive, needs enable
// [R15] reset and software reset leave four-lane command mode off
// [R16] 66h then 99h resets over 30us, no commands meanwhile
// [R17] shared pin is pause when select 0, active-low reset when 1
// [R18] hard reset held 1us returns to power-on state, aborts operation
// [R19] four lane enable disables pause and reset on shared pin
// [R20] hard reset overrides every other input; rstn_i takes priority over it and the sclk link logic ignores it
// [R21] host reads status before each command; the bench host never sends a status read
// [R22] data-changing commands refused while write latch clear
// [R23] invert off: 000 none, 111 all, fractions or 4K-32K edge regions
// [R24] pause disabled in quad mode
// [R25] enable-reset cancelled if next command is not reset
`timescale 1ns/100ps
`default_nettype none
module sffp_front_end
  import sffp_pkg::*;
#(
  parameter int SW_RESET_CYCLES = SW_RESET_CYC,
  parameter int OP_BUSY_CYCLES  = 1000
) (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_o,
  input  wire sffp_cfg_s  cfg_i,
  input  wire logic [7:0] read_data_i,
  input  wire logic       lock_clr_i,
  input  wire logic [SECT_IDX_W-1:0] lock_idx_i,
  output sffp_cmd_s       exec_o,
  output logic            write_latch_o,
  output logic            busy_o,
  output logic            four_lane_command_mode_o,
  output logic            paused_o,
  output logic            reject_o
);
  // ---- link domain (sclk) ----
  logic [5:0]  bit_cnt;
  logic [31:0] shreg;
  logic        frame_tog;
  logic [31:0] frame_word;
  logic [5:0]  frame_bits;
  logic [7:0]  opc_q;
  logic [7:0]  frame_opc;
  logic [7:0]  out_byte;
  logic [2:0]  out_ptr;
  logic        link_4l_q1, link_4l_q2, link_lock_q1, link_lock_q2;
  wire cmd_4l  = link_4l_q2;
  // opcode is latched once its last bit arrives; the shifter moves on with address bits
  wire [7:0] opc_now = opc_q;
  wire dual_rd = (opc_now == CMD_DREAD) || (opc_now == CMD_2READ); // [R12]
  wire quad_rd = cfg_i.four_lane_enable &&
                 ((opc_now == CMD_QREAD) || (opc_now == CMD_4READ)); // [R13]
  wire [5:0] bits_per = cmd_4l ? 6'd4 : 6'd1;
  wire [3:0] in_bits  = io_i;
  wire [31:0] shreg_1 = {shreg[30:0], in_bits[0]};
  wire [31:0] shreg_4 = {shreg[27:0], in_bits};
  wire is_read = (opc_now == CMD_READ) || (opc_now == CMD_FREAD) || dual_rd || quad_rd ||
                 (opc_now == CMD_STATUS_RD);
  wire data_phase = is_read && (bit_cnt >= (cmd_4l ? 6'd8 : 6'd32)) && !link_lock_q2;
  // [R8] sample on rising edge; frame boundaries come from select itself
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt <= 6'h00;
      shreg   <= 32'h0000_0000;
      opc_q   <= 8'h00;
    end else begin
      shreg   <= cmd_4l ? shreg_4 : shreg_1;
      if (bit_cnt == (cmd_4l ? 6'd4 : 6'd7)) begin
        opc_q <= cmd_4l ? shreg_4[7:0] : shreg_1[7:0];
      end
      bit_cnt <= (bit_cnt > 6'd39) ? bit_cnt : 6'(bit_cnt + bits_per);
    end
  end
  // frame end captured at select rise; the core picks it up by toggle
  always_ff @(posedge cs_n_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_tog  <= 1'b0;
      frame_word <= 32'h0000_0000;
      frame_bits <= 6'h00;
      frame_opc  <= 8'h00;
    end else begin
      frame_tog  <= ~frame_tog;
      frame_word <= shreg;
      frame_opc  <= opc_q;
      frame_bits <= bit_cnt;
    end
  end
  // [R8] shift out on falling edge
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      out_ptr <= 3'h0;
      out_byte <= 8'h00;
    end else if (data_phase) begin // [R9]
      out_ptr <= 3'(out_ptr + 3'h1);
      if (out_ptr == 3'h0) begin
        out_byte <= read_data_i;
      end
    end
  end
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_4l_q1 <= 1'b0;
      link_4l_q2 <= 1'b0;
      link_lock_q1 <= 1'b0;
      link_lock_q2 <= 1'b0;
    end else begin
      link_4l_q1 <= four_lane_command_mode_o;
      link_4l_q2 <= link_4l_q1;
      link_lock_q1 <= busy_o;
      link_lock_q2 <= link_lock_q1;
    end
  end
  // ---- core domain ----
  logic [2:0] tog_sync;
  logic [1:0] sh_pin_sync;
  logic [1:0] cs_sync;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tog_sync    <= 3'h0;
      sh_pin_sync <= 2'b11;
      cs_sync     <= 2'b11;
    end else begin
      tog_sync    <= {tog_sync[1:0], frame_tog};
      sh_pin_sync <= {sh_pin_sync[0], io_i[3]};
      cs_sync     <= {cs_sync[0], cs_n_i};
    end
  end
  wire frame_done = tog_sync[2] ^ tog_sync[1];
  wire shared_pin = sh_pin_sync[1];
  // [R17] [R19] [R24] shared pin function select
  wire pin_is_reset = cfg_i.pause_reset_select && !cfg_i.four_lane_enable;
  wire pin_is_pause = !cfg_i.pause_reset_select && !cfg_i.four_lane_enable && !cmd_4l;
  assign paused_o = pin_is_pause && !shared_pin && !cs_sync[1];
  logic [15:0] hr_cnt;
  wire hard_reset = pin_is_reset && !shared_pin && (hr_cnt >= 16'(HARD_RESET_CYC)); // [R18]
  wire [7:0]        f_opc  = frame_opc;
  wire [ADDR_W-1:0] f_addr = frame_word[ADDR_W-1:0];
  wire f_aligned = (frame_bits[2:0] == 3'h0);
  sffp_state_e state;
  logic [31:0] timer;
  logic        write_latch;
  logic        reset_armed;
  logic        four_lane_mode;
  logic [SECTOR_COUNT-1:0] lock_bits;
  function automatic logic sect_in_range(input logic [4:0] sel, input logic inv,
                                         input logic [SECT_IDX_W-1:0] s);
    logic hit;
    logic [3:0] sh;
    hit = 1'b0;
    sh  = 4'h0;
    // [R23] normal decode
    if (sel[2:0] == 3'b111) begin
      hit = 1'b1;
    end else if (sel[2:0] == 3'b000) begin
      hit = 1'b0;
    end else if (!sel[4]) begin
      sh  = 4'(4'd6 - {1'b0, sel[2:0]} + 4'd1);
      if (sel[3]) hit = (s >> (4'd11 - sh)) == 11'h000;
      else        hit = (~s >> (4'd11 - sh)) == 11'h000;
    end else begin
      sh  = (sel[2]) ? 4'd3 : 4'(sel[1:0] - 2'd1);
      if (sel[3]) hit = (s >> sh) == 11'h000;
      else        hit = ((~s) >> sh) == 11'h000;
    end
    sect_in_range = inv ? !hit : hit; // [R1]
  endfunction : sect_in_range
  function automatic logic [SECT_IDX_W:0] span_of(input logic [7:0] op);
    case (op)
      CMD_SECT_ERASE, CMD_PAGE_PROG: span_of = 12'd1; // [R5]
      CMD_BLK32: span_of = 12'd8;
      CMD_BLK64: span_of = 12'd16;
      default:   span_of = 12'd2048;
    endcase
  endfunction : span_of
  // [R2] [R3] region hit: check every sector of the target span
  logic region_prot;
  wire [SECT_IDX_W-1:0] base_sect = f_addr[ADDR_W-1:12];
  wire [SECT_IDX_W:0]   span = span_of(f_opc);
  always_comb begin
    region_prot = 1'b0;
    for (int i = 0; i < SECTOR_COUNT; i++) begin
      if ((i >= (base_sect & ~11'(span - 12'd1))) && (i < ({1'b0, base_sect & ~11'(span - 12'd1)} + span))) begin
        if (cfg_i.lock_scheme_select ? lock_bits[i] // [R3]
            : sect_in_range(cfg_i.prot_sel, cfg_i.range_invert_bit, 11'(i)))
          region_prot = 1'b1;
      end
    end
  end
  wire f_write_class = (f_opc == CMD_PAGE_PROG) || (f_opc == CMD_SECT_ERASE) ||
                       (f_opc == CMD_BLK32) || (f_opc == CMD_BLK64) ||
                       (f_opc == CMD_CHIP_A) || (f_opc == CMD_CHIP_B);
  wire f_known = f_write_class || (f_opc == CMD_WRITE_UNLOCK) || (f_opc == CMD_WRITE_LOCK) ||
                 (f_opc == CMD_STATUS_WR) || (f_opc == CMD_ENTER_4L) ||
                 (f_opc == CMD_EXIT_4L) || (f_opc == CMD_RESET_EN) || (f_opc == CMD_RESET);
  wire needs_align = f_known; // [R10]
  wire accept = frame_done && f_known && (!needs_align || f_aligned) && (state == ST_IDLE);
  wire go_prog = accept && (f_write_class || f_opc == CMD_STATUS_WR) && write_latch && // [R22]
                 !(f_write_class && region_prot); // [R2]
  assign reject_o = frame_done && !(accept && (!f_write_class || go_prog));
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hr_cnt <= 16'h0000;
    end else begin
      hr_cnt <= (pin_is_reset && !shared_pin) ? ((hr_cnt == 16'hFFFF) ? hr_cnt : 16'(hr_cnt + 16'h1)) : 16'h0000;
    end
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      timer <= 32'h0000_0000;
      write_latch <= 1'b0;
      reset_armed <= 1'b0;
      four_lane_mode <= 1'b0; // [R15]
      lock_bits <= '1; // [R4]
      exec_o <= '0;
    end else if (hard_reset) begin // [R20] [R18]
      state <= ST_IDLE;
      timer <= 32'h0000_0000;
      write_latch <= 1'b0;
      reset_armed <= 1'b0;
      four_lane_mode <= 1'b0;
      lock_bits <= '1;
      exec_o <= '0;
    end else begin
      exec_o.valid <= 1'b0;
      if (lock_clr_i && state == ST_IDLE) lock_bits[lock_idx_i] <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (accept) begin
            reset_armed <= (f_opc == CMD_RESET_EN); // [R25]
            if (f_opc == CMD_RESET && reset_armed) begin // [R16]
              state <= ST_RESET;
              timer <= 32'(SW_RESET_CYCLES);
            end
            if (f_opc == CMD_WRITE_UNLOCK) write_latch <= 1'b1;
            if (f_opc == CMD_WRITE_LOCK)   write_latch <= 1'b0;
            if (f_opc == CMD_ENTER_4L && cfg_i.four_lane_enable) four_lane_mode <= 1'b1; // [R14]
            if (f_opc == CMD_EXIT_4L) four_lane_mode <= 1'b0;
            if (go_prog) begin
              state <= ST_BUSY; // [R11]
              timer <= 32'(OP_BUSY_CYCLES);
              write_latch <= 1'b0;
              exec_o <= '{valid: 1'b1, opcode: f_opc, addr: f_addr, byte_aligned: f_aligned};
            end
          end else if (frame_done) begin
            reset_armed <= 1'b0; // [R25]
          end
        end
        ST_RESET: begin
          if (timer == 32'h0) begin
            state <= ST_IDLE;
            write_latch <= 1'b0;
            four_lane_mode <= 1'b0; // [R15]
            lock_bits <= '1;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        ST_BUSY: begin
          if (timer == 32'h0) state <= ST_IDLE;
          else timer <= timer - 32'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  assign write_latch_o = write_latch;
  assign four_lane_command_mode_o = four_lane_mode;
  assign busy_o = (state != ST_IDLE);
  // [R6] [R7] [R12] [R13] output lanes: tristate unless a valid read is in data phase
  // pointer has already advanced past the bit on the lane, so msb shows at pointer 1
  wire [2:0] bi = 3'(3'h0 - out_ptr);
  always_comb begin
    io_o    = 4'h0;
    io_oe_o = 4'h0;
    if (!cs_n_i && data_phase && !paused_o) begin
      if (cmd_4l || quad_rd) begin
        io_o = out_ptr[0] ? out_byte[3:0] : out_byte[7:4];
        io_oe_o = 4'hF;
      end else if (dual_rd) begin
        io_o = {2'b00, out_byte[bi], out_byte[3'(bi - 3'h1)]};
        io_oe_o = 4'h3;
      end else begin
        io_o = {2'b00, out_byte[bi], 1'b0};
        io_oe_o = 4'h2;
      end
    end
  end
endmodule : sffp_front_end
`default_nettype wire

// File: rtl/sffp_pkg.sv
// package for the serial flash front end: geometry, commands, timing
package sffp_pkg;
  localparam int ADDR_W          = 23;
  localparam int PAGE_BYTES      = 256;
  localparam int SECTOR_BYTES    = 4096;
  localparam int SECTOR_COUNT    = 2048;
  localparam int SECT_IDX_W      = 11;
  localparam int CORE_CLK_MHZ    = 250;
  localparam int SW_RESET_NS     = 30000;
  localparam int SW_RESET_CYC    = (SW_RESET_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int HARD_RESET_MIN_PULSE_NS = 1000;
  localparam int HARD_RESET_CYC  = (HARD_RESET_MIN_PULSE_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] CMD_READ      = 8'h03;
  localparam logic [7:0] CMD_FREAD     = 8'h0B;
  localparam logic [7:0] CMD_DREAD     = 8'h3B;
  localparam logic [7:0] CMD_2READ     = 8'hBB;
  localparam logic [7:0] CMD_QREAD     = 8'h6B;
  localparam logic [7:0] CMD_4READ     = 8'hEB;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
  localparam logic [7:0] CMD_SECT_ERASE= 8'h20;
  localparam logic [7:0] CMD_BLK32     = 8'h52;
  localparam logic [7:0] CMD_BLK64     = 8'hD8;
  localparam logic [7:0] CMD_CHIP_A    = 8'h60;
  localparam logic [7:0] CMD_CHIP_B    = 8'hC7;
  localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] CMD_WRITE_LOCK   = 8'h04;
  localparam logic [7:0] CMD_STATUS_RD    = 8'h05;
  localparam logic [7:0] CMD_STATUS_WR    = 8'h01;
  localparam logic [7:0] CMD_ENTER_4L     = 8'h38;
  localparam logic [7:0] CMD_EXIT_4L      = 8'hFF;
  localparam logic [7:0] CMD_RESET_EN     = 8'h66;
  localparam logic [7:0] CMD_RESET        = 8'h99;
  localparam logic [3:0] ALL_PROT_COUNT   = 4'hF;
  typedef struct packed {
    logic [4:0] prot_sel;
    logic       range_invert_bit;
    logic       lock_scheme_select;
    logic       four_lane_enable;
    logic       pause_reset_select;
  } sffp_cfg_s;
  typedef struct packed {
    logic              valid;
    logic [7:0]        opcode;
    logic [ADDR_W-1:0] addr;
    logic              byte_aligned;
  } sffp_cmd_s;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_EXEC  = 4'b0010,
    ST_RESET = 4'b0100,
    ST_BUSY  = 4'b1000
  } sffp_state_e;
endpackage : sffp_pkg
